// file: hw/icc_map.vh
`ifndef ICC_MAP_VH
`define ICC_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define ICC_OFS_MODE     8'h00
`define ICC_OFS_STATUS   8'h04
`define ICC_OFS_LOW      8'h08
`define ICC_OFS_HIGH     8'h0c
`define ICC_OFS_HOLD     8'h10
`define ICC_OFS_DATA     8'h14
`define ICC_OFS_OWN      8'h18
// ****************************************
// mode_control_reg fields
// ****************************************
`define ICC_MD_EVT       7
`define ICC_MD_ENABLE    6
`define ICC_MD_SRST      5
`define ICC_MD_IRQEN     4
`define ICC_MD_ACK_ENABLE     3
`define ICC_MD_MASTER    2
`define ICC_MD_STOP      1
`define ICC_MD_START     0
// ****************************************
// bus_state_reg fields
// ****************************************
`define ICC_ST_ADDRACK   7
`define ICC_ST_DONE      6
`define ICC_ST_STOP      5
`define ICC_ST_SSEL      4
`define ICC_ST_ARBLOST   3
`define ICC_ST_BUSY      2
`define ICC_ST_TMODE     1
`define ICC_ST_ACK       0
// ****************************************
// own_address_reg fields
// ****************************************
`define ICC_OA_GCEN      0
// ****************************************
// reset values
// ****************************************
`define ICC_RST_LOW      8'h3f
`define ICC_RST_HIGH     8'h3f
`define ICC_RST_HOLD     8'h01
`define ICC_RST_DATA     8'hff
`define ICC_RST_OWN      8'h00
// ****************************************
// bus responses
// ****************************************
`define ICC_RESP_OKAY    2'b00
`define ICC_RESP_SLVERR  2'b10
`endif

// file: hw/icc_ctrl.v
// Overview of operation
// - enable bit runs the controller; software sets it, plus ack enable for slave use
// - SCL low and high phases timed from the two period registers
// - SDA changes delayed after each SCL fall by the hold count
// - hold time is hold count plus one core clock periods after the fall is seen; zero allowed
// - start request as master drives START then shifts out data register byte
// - master samples slave acknowledge in ninth SCL high phase into status
// - master raises event after address byte either way; address-acknowledge status set only if slave acknowledged
// - lost arbitration sets flag, goes idle or continues as matching addressed slave
// - every acknowledge stage stretches SCL low until software decides
// - any status register write releases held SCL
// - stop request as master generates STOP after releasing SCL
// - start request in held stage gives repeated START and new address phase
// - master receiver raises byte-done and holds SCL after each byte
// - receiver acknowledges per ack enable; cleared marks master's last byte
// - STOP sets stop status; status write then returns to idle
// - after START the slave receives a byte and compares seven address bits
// - general call enable also matches address zero
// - mismatch or ack enable cleared sends slave back to idle
// - match with ack enable raises slave-selected event and holds SCL
// - after each slave data byte raise byte-done and hold SCL regardless of ack
// - slave detects repeated START anytime; transmitter after nack waits STOP/START
// - each event sets event flag; status write clears it and frees SCL
// - events follow every bus event except any START and a STOP while not addressed
// - acknowledge drives SDA low when ack enable is one, else released
`timescale 1ns/1ps
`include "icc_map.vh"

module icc_ctrl #(
	parameter ADDR_W = 8
) (
	input  wire              core_clk,
	input  wire              rst,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              sclIn,
	output reg               sclOut,
	output reg               sclOe,
	input  wire              sdaIn,
	output reg               sdaOut,
	output reg               sdaOe
);

localparam ST_IDLE  = 3'd0;
localparam ST_XFER  = 3'd1;
localparam ST_HOLD  = 3'd2;
localparam ST_START = 3'd3;
localparam ST_STOP  = 3'd4;
localparam ST_WAIT  = 3'd5;

// ****************************************
// registers
// ****************************************
reg [2:0] state_r;
reg [1:0] phase_r;
reg [7:0] tmr_r;
reg [7:0] hold_r;
reg       updPend_r;
reg [3:0] bitCnt_r;
reg       addrPhase_r;
reg       txMode_r;
reg       addressed_r;
reg       nackWait_r;
reg       gcallHit_r;
reg       blockEnable_r;
reg       softRst_r;
reg       irqEnable_r;
reg       ackEnable_r;
reg       isMaster_r;
reg       stopReq_r;
reg       startReq_r;
reg       evtFlag_r;
reg       addrAckGc_r;
reg       byteDone_r;
reg       stopSeen_r;
reg       slaveSel_r;
reg       arbLost_r;
reg       busy_r;
reg       ackReceived_r;
reg [7:0] clockLowPeriodReg_r;
reg [7:0] clockHighPeriodReg_r;
reg [7:0] dataHoldReg_r;
reg [7:0] shiftDataReg_r;
reg [7:0] ownAddressReg_r;
reg [1:0] sclSync_r;
reg [1:0] sdaSync_r;
reg       sclPrev_r;
reg       sdaPrev_r;
reg [7:0] rdByte;
reg       rdHit;

// ****************************************
// pin synchronisers and bus events
// ****************************************
always @(posedge core_clk) begin
	if (rst) begin
		sclSync_r <= 2'h3;
		sdaSync_r <= 2'h3;
		sclPrev_r <= 1'b1;
		sdaPrev_r <= 1'b1;
	end else begin
		sclSync_r <= {sclSync_r[0], sclIn};
		sdaSync_r <= {sdaSync_r[0], sdaIn};
		sclPrev_r <= sclSync_r[1];
		sdaPrev_r <= sdaSync_r[1];
	end
end

wire sclNow   = sclSync_r[1];
wire sdaNow   = sdaSync_r[1];
wire sclRise  = sclNow & ~sclPrev_r;
wire sclFall  = ~sclNow & sclPrev_r;
wire startDet = sclNow & sclPrev_r & sdaPrev_r & ~sdaNow;
wire stopDet  = sclNow & sclPrev_r & ~sdaPrev_r & sdaNow;

// ****************************************
// bus slave handshakes
// ****************************************
wire wrFire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
wire rdFire = s_axi_arvalid & s_axi_arready;
wire wrLow  = wrFire & s_axi_wstrb[0];
wire wrMode = wrLow & (s_axi_awaddr == `ICC_OFS_MODE);
// the write itself is the release: data and strobes do not matter
wire statusWr = wrFire & (s_axi_awaddr == `ICC_OFS_STATUS);

always @* begin
	rdHit = 1'b1;
	case (s_axi_araddr)
	`ICC_OFS_MODE:   rdByte = {evtFlag_r, blockEnable_r, softRst_r, irqEnable_r,
	                           ackEnable_r, isMaster_r, stopReq_r, startReq_r};
	`ICC_OFS_STATUS: rdByte = {addrAckGc_r, byteDone_r, stopSeen_r, slaveSel_r,
	                           arbLost_r, busy_r, txMode_r, ackReceived_r};
	`ICC_OFS_LOW:    rdByte = clockLowPeriodReg_r;
	`ICC_OFS_HIGH:   rdByte = clockHighPeriodReg_r;
	`ICC_OFS_HOLD:   rdByte = dataHoldReg_r;
	`ICC_OFS_DATA:   rdByte = shiftDataReg_r;
	`ICC_OFS_OWN:    rdByte = ownAddressReg_r;
	default: begin
		rdByte = 8'h00;
		rdHit  = 1'b0;
	end
	endcase
end

always @(posedge core_clk) begin
	if (rst) begin
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `ICC_RESP_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rresp   <= `ICC_RESP_OKAY;
		s_axi_rdata   <= 32'h00000000;
	end else begin
		// both channels are taken together, so either arrival order works
		s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
		s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
		if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr <= `ICC_OFS_OWN)
			                ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
		if (rdFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rdByte};
			s_axi_rresp  <= rdHit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

// ****************************************
// bit engine helpers
// ****************************************
wire       txNow   = addrPhase_r ? isMaster_r : txMode_r;
wire       ackDrv  = addrPhase_r ? ~isMaster_r : (~txNow & ackEnable_r);
wire [7:0] shiftIn = {shiftDataReg_r[6:0], sdaNow};
wire       ownHit  = shiftIn[7:1] == ownAddressReg_r[7:1];
wire       gcHit   = ownAddressReg_r[`ICC_OA_GCEN] & (shiftIn[7:1] == 7'h00);
wire       sdaWant = (state_r == ST_XFER) &
                     ((bitCnt_r < 4'd8) ? (txNow & ~shiftDataReg_r[7])
                                        : ((bitCnt_r == 4'd8) & ackDrv));
// a master driving one but seeing zero has lost the bus
wire       arbLose = (state_r == ST_XFER) & sclRise & isMaster_r & txNow &
                     (bitCnt_r < 4'd8) & ~sdaOe & ~sdaNow;

// ****************************************
// controller
// ****************************************
always @(posedge core_clk) begin
	if (rst) begin
		state_r              <= ST_IDLE;
		phase_r              <= 2'h0;
		tmr_r                <= 8'h00;
		hold_r               <= 8'h00;
		updPend_r            <= 1'b0;
		bitCnt_r             <= 4'h0;
		addrPhase_r          <= 1'b0;
		txMode_r             <= 1'b0;
		addressed_r          <= 1'b0;
		nackWait_r           <= 1'b0;
		gcallHit_r           <= 1'b0;
		blockEnable_r        <= 1'b0;
		softRst_r            <= 1'b0;
		irqEnable_r          <= 1'b0;
		ackEnable_r          <= 1'b0;
		isMaster_r           <= 1'b0;
		stopReq_r            <= 1'b0;
		startReq_r           <= 1'b0;
		evtFlag_r            <= 1'b0;
		addrAckGc_r          <= 1'b0;
		byteDone_r           <= 1'b0;
		stopSeen_r           <= 1'b0;
		slaveSel_r           <= 1'b0;
		arbLost_r            <= 1'b0;
		busy_r               <= 1'b0;
		ackReceived_r        <= 1'b0;
		clockLowPeriodReg_r  <= `ICC_RST_LOW;
		clockHighPeriodReg_r <= `ICC_RST_HIGH;
		dataHoldReg_r        <= `ICC_RST_HOLD;
		shiftDataReg_r       <= `ICC_RST_DATA;
		ownAddressReg_r      <= `ICC_RST_OWN;
		sclOe                <= 1'b0;
		sdaOe                <= 1'b0;
		sclOut               <= 1'b0;
		sdaOut               <= 1'b0;
	end else begin
		softRst_r <= 1'b0;
		if (wrMode) begin
			blockEnable_r <= s_axi_wdata[`ICC_MD_ENABLE];
			softRst_r     <= s_axi_wdata[`ICC_MD_SRST];
			irqEnable_r   <= s_axi_wdata[`ICC_MD_IRQEN];
			ackEnable_r   <= s_axi_wdata[`ICC_MD_ACK_ENABLE];
			stopReq_r     <= s_axi_wdata[`ICC_MD_STOP];
			startReq_r    <= s_axi_wdata[`ICC_MD_START];
		end
		if (wrLow && s_axi_awaddr == `ICC_OFS_LOW)
			clockLowPeriodReg_r <= s_axi_wdata[7:0];
		if (wrLow && s_axi_awaddr == `ICC_OFS_HIGH)
			clockHighPeriodReg_r <= s_axi_wdata[7:0];
		if (wrLow && s_axi_awaddr == `ICC_OFS_HOLD)
			dataHoldReg_r <= s_axi_wdata[7:0];
		if (wrLow && s_axi_awaddr == `ICC_OFS_DATA)
			shiftDataReg_r <= s_axi_wdata[7:0];
		if (wrLow && s_axi_awaddr == `ICC_OFS_OWN)
			ownAddressReg_r <= s_axi_wdata[7:0];
		// clears come first so that a same-cycle event below wins
		if (statusWr) begin
			evtFlag_r   <= 1'b0;
			addrAckGc_r <= 1'b0;
			byteDone_r  <= 1'b0;
			stopSeen_r  <= 1'b0;
			slaveSel_r  <= 1'b0;
			arbLost_r   <= 1'b0;
		end
		if (startDet)
			busy_r <= 1'b1;
		else if (stopDet)
			busy_r <= 1'b0;

		if (!blockEnable_r || softRst_r) begin
			state_r     <= ST_IDLE;
			sclOe       <= 1'b0;
			sdaOe       <= 1'b0;
			isMaster_r  <= 1'b0;
			addressed_r <= 1'b0;
			nackWait_r  <= 1'b0;
			updPend_r   <= 1'b0;
			if (softRst_r) begin
				evtFlag_r   <= 1'b0;
				addrAckGc_r <= 1'b0;
				byteDone_r  <= 1'b0;
				stopSeen_r  <= 1'b0;
				slaveSel_r  <= 1'b0;
				arbLost_r   <= 1'b0;
			end
		end else begin
			// data changes only a hold count after each falling SCL
			if (state_r == ST_XFER || state_r == ST_HOLD) begin
				if (sclFall) begin
					hold_r    <= dataHoldReg_r;
					updPend_r <= 1'b1;
				end else if (updPend_r) begin
					if (hold_r == 8'h00) begin
						updPend_r <= 1'b0;
						sdaOe     <= sdaWant;
					end else begin
						hold_r <= hold_r - 8'h01;
					end
				end
			end
			case (state_r)
			ST_IDLE: begin
				if (startReq_r && !busy_r) begin
					startReq_r <= 1'b0;
					isMaster_r <= 1'b1;
					state_r    <= ST_START;
					phase_r    <= 2'h0;
					tmr_r      <= 8'h00;
				end
			end
			ST_XFER: begin
				if (isMaster_r) begin
					if (sclOe) begin
						// low phase counts from the fall as seen, in step with the hold count
						if (sclNow) begin
							tmr_r <= 8'h00;
						end else if (tmr_r >= clockLowPeriodReg_r) begin
							sclOe <= 1'b0;
							tmr_r <= 8'h00;
						end else begin
							tmr_r <= tmr_r + 8'h01;
						end
					end else if (sclNow) begin
						if (tmr_r >= clockHighPeriodReg_r) begin
							sclOe <= 1'b1;
							tmr_r <= 8'h00;
						end else begin
							tmr_r <= tmr_r + 8'h01;
						end
					end
				end
				if (sclRise) begin
					if (bitCnt_r < 4'd8) begin
						shiftDataReg_r <= shiftIn;
						bitCnt_r       <= bitCnt_r + 4'd1;
						if (arbLose) begin
							arbLost_r  <= 1'b1;
							evtFlag_r  <= 1'b1;
							isMaster_r <= 1'b0;
							sclOe      <= 1'b0;
							if (!addrPhase_r)
								state_r <= ST_IDLE;
						end
						if (bitCnt_r == 4'd7 && addrPhase_r && (!isMaster_r || arbLose)) begin
							if (!(ownHit || gcHit) || !ackEnable_r) begin
								state_r <= ST_IDLE;
							end else begin
								gcallHit_r <= gcHit;
								txMode_r   <= shiftIn[0];
							end
						end
					end else if (bitCnt_r == 4'd8) begin
						ackReceived_r <= ~sdaNow;
						bitCnt_r      <= 4'd9;
					end
				end else if (sclFall && bitCnt_r == 4'd9) begin
					// the stretch does not depend on irq enable
					sclOe     <= 1'b1;
					state_r   <= ST_HOLD;
					evtFlag_r <= 1'b1;
					if (addrPhase_r && isMaster_r) begin
						addrAckGc_r <= ackReceived_r;
						txMode_r    <= ~shiftDataReg_r[0];
					end else if (addrPhase_r) begin
						slaveSel_r  <= 1'b1;
						addrAckGc_r <= gcallHit_r;
						addressed_r <= 1'b1;
					end else begin
						byteDone_r <= 1'b1;
						nackWait_r <= ~isMaster_r & txMode_r & ~ackReceived_r;
					end
				end
			end
			ST_HOLD: begin
				if (statusWr) begin
					tmr_r   <= 8'h00;
					phase_r <= 2'h0;
					if (isMaster_r && stopReq_r) begin
						stopReq_r <= 1'b0;
						state_r   <= ST_STOP;
					end else if (isMaster_r && startReq_r) begin
						startReq_r <= 1'b0;
						state_r    <= ST_START;
					end else if (nackWait_r) begin
						sclOe      <= 1'b0;
						nackWait_r <= 1'b0;
						state_r    <= ST_IDLE;
					end else begin
						// a slave sets its first bit in the same cycle that it lets SCL go
						state_r     <= ST_XFER;
						bitCnt_r    <= 4'h0;
						addrPhase_r <= 1'b0;
						updPend_r   <= 1'b0;
						sclOe       <= isMaster_r;
						sdaOe       <= txMode_r & ~shiftDataReg_r[7];
					end
				end
			end
			ST_START: begin
				case (phase_r)
				2'h0: begin
					sdaOe <= 1'b0;
					if (tmr_r >= clockLowPeriodReg_r) begin
						sclOe   <= 1'b0;
						tmr_r   <= 8'h00;
						phase_r <= 2'h1;
					end else begin
						tmr_r <= tmr_r + 8'h01;
					end
				end
				2'h1: begin
					if (sclNow && sdaNow) begin
						if (tmr_r >= clockHighPeriodReg_r) begin
							sdaOe   <= 1'b1;
							tmr_r   <= 8'h00;
							phase_r <= 2'h2;
						end else begin
							tmr_r <= tmr_r + 8'h01;
						end
					end
				end
				default: begin
					if (tmr_r >= clockHighPeriodReg_r) begin
						sclOe       <= 1'b1;
						tmr_r       <= 8'h00;
						state_r     <= ST_XFER;
						bitCnt_r    <= 4'h0;
						addrPhase_r <= 1'b1;
					end else begin
						tmr_r <= tmr_r + 8'h01;
					end
				end
				endcase
			end
			ST_STOP: begin
				if (phase_r == 2'h0) begin
					sdaOe <= 1'b1;
					if (tmr_r >= clockLowPeriodReg_r) begin
						sclOe   <= 1'b0;
						tmr_r   <= 8'h00;
						phase_r <= 2'h1;
					end else begin
						tmr_r <= tmr_r + 8'h01;
					end
				end else if (sclNow) begin
					if (tmr_r >= clockHighPeriodReg_r) begin
						sdaOe      <= 1'b0;
						stopSeen_r <= 1'b1;
						evtFlag_r  <= 1'b1;
						isMaster_r <= 1'b0;
						state_r    <= ST_WAIT;
					end else begin
						tmr_r <= tmr_r + 8'h01;
					end
				end
			end
			ST_WAIT: begin
				if (statusWr)
					state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
			// other masters' START and STOP, watched only while not mastering
			if (!isMaster_r && state_r != ST_START && state_r != ST_STOP) begin
				if (startDet) begin
					state_r     <= ST_XFER;
					bitCnt_r    <= 4'h0;
					addrPhase_r <= 1'b1;
					nackWait_r  <= 1'b0;
					updPend_r   <= 1'b0;
					sdaOe       <= 1'b0;
					sclOe       <= 1'b0;
				end else if (stopDet && addressed_r) begin
					stopSeen_r  <= 1'b1;
					evtFlag_r   <= 1'b1;
					addressed_r <= 1'b0;
					sdaOe       <= 1'b0;
					sclOe       <= 1'b0;
					state_r     <= ST_WAIT;
				end
			end
		end
	end
end

endmodule

// file: dv/icc_ctrl_checker.sv
`timescale 1ns/1ps
`include "icc_map.vh"
module icc_ctrl_checker #(
	parameter ADDR_W = 8
) (
	input wire              core_clk,
	input wire              rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire              s_axi_awvalid,
	input wire              s_axi_awready,
	input wire [31:0]       s_axi_wdata,
	input wire [3:0]        s_axi_wstrb,
	input wire              s_axi_wvalid,
	input wire              s_axi_wready,
	input wire [1:0]        s_axi_bresp,
	input wire              s_axi_bvalid,
	input wire              s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire [31:0]       s_axi_rdata,
	input wire [1:0]        s_axi_rresp,
	input wire              s_axi_rvalid,
	input wire              s_axi_rready,
	input wire              sclIn,
	input wire              sclOut,
	input wire              sclOe,
	input wire              sdaIn,
	input wire              sdaOut,
	input wire              sdaOe
);
	// ********
	// helpers
	// ********
	wire wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire stWr    = wrTaken && s_axi_awaddr == `ICC_OFS_STATUS;
	wire badAddr = s_axi_awaddr > `ICC_OFS_OWN || s_axi_awaddr[1:0] != 2'b00;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ready_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("write readies split");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write ready longer than one cycle");
	a_wr_answer: assert property (wrTaken |=> s_axi_bvalid
		&& s_axi_bresp == ($past(badAddr) ? `ICC_RESP_SLVERR : `ICC_RESP_OKAY))
		else $error("write response late or wrong");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& s_axi_rdata[31:8] == 24'h000000)
		else $error("read answer late or upper bits set");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_pull_only: assert property (!sclOut && !sdaOut)
		else $error("line driven high");
	a_sda_hold: assert property ($fell(sclIn) |=> $stable(sdaOe))
		else $error("sda moved right after scl fall");
	a_status_release: assert property (stWr && sclOe |-> ##[1:100] !sclOe)
		else $error("scl kept low after status write");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sclOe && !sdaOe
		&& !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active in reset");
	c_stretch: cover property (stWr && sclOe);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `ICC_RESP_SLVERR);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind icc_ctrl icc_ctrl_checker #(.ADDR_W(ADDR_W)) icc_ctrl_checker_inst (
	.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// file: dv/icc_bus_peer.sv
`timescale 1ns/1ps
// ********
// far-side target: acks its address and write bytes
// ********
module icc_bus_peer #(
	parameter [6:0] OWN_ADDR = 7'h2a
) (
	input  wire       scl,
	input  wire       sda,
	output reg        sdaPull,
	output reg  [7:0] lastByte,
	output reg  [7:0] nStops
);
	reg     [7:0] sh;
	reg           active;
	reg           inAddr;
	reg           sel;
	integer       cnt;
	initial begin
		sdaPull = 1'b0;
		lastByte = 8'h00;
		nStops = 8'h00;
		active = 1'b0;
		inAddr = 1'b0;
		sel = 1'b0;
		cnt = 0;
	end
	// start and repeated start restart the address byte
	always @(negedge sda) if (scl === 1'b1) begin
		// the fall that closes the start carries no bit
		cnt = -1;
		active = 1'b1;
		inAddr = 1'b1;
	end
	always @(posedge sda) if (scl === 1'b1 && active) begin
		nStops = nStops + 8'h01;
		active = 1'b0;
		sel = 1'b0;
	end
	// msb first, sampled while scl is high
	always @(posedge scl) if (active && cnt < 8) sh = {sh[6:0], sda};
	always @(negedge scl) if (active) begin
		cnt = cnt + 1;
		if (cnt == 8) begin
			lastByte = sh;
			if (inAddr) sel = sh[7:1] == OWN_ADDR && !sh[0];
			sdaPull <= #1 sel;
		end else if (cnt == 9) begin
			// release right after the ninth fall; the pull-up brings sda back
			sdaPull <= #1 1'b0;
			cnt = 0;
			inAddr = 1'b0;
		end
	end
endmodule

// file: dv/icc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "icc_map.vh"
module icc_ctrl_tb_top;
	localparam [6:0] PEER = 7'h2a;
	localparam [55:0] RV = {8'h00, 8'h00, `ICC_RST_LOW, `ICC_RST_HIGH, `ICC_RST_HOLD,
		`ICC_RST_DATA, `ICC_RST_OWN};
	reg         core_clk;
	reg         rst;
	reg  [7:0]  s_axi_awaddr;
	reg  [7:0]  s_axi_araddr;
	reg  [31:0] s_axi_wdata;
	reg         s_axi_awvalid;
	reg         s_axi_wvalid;
	reg         s_axi_bready;
	reg         s_axi_arvalid;
	reg         s_axi_rready;
	wire        s_axi_awready;
	wire        s_axi_wready;
	wire        s_axi_bvalid;
	wire        s_axi_arready;
	wire        s_axi_rvalid;
	wire [1:0]  s_axi_bresp;
	wire [1:0]  s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        sclOe;
	wire        sdaOe;
	wire        peerPull;
	wire [7:0]  peerByte;
	wire [7:0]  peerStops;
	wire        scl = ~sclOe;
	wire        sda = ~(sdaOe | peerPull);
	integer     errors;
	integer     n_compared;
	integer     i;
	reg  [31:0] d;
	reg  [1:0]  r;
	icc_ctrl icc_ctrl_inst (
		.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda),
		.sdaOut(), .sdaOe(sdaOe));
	icc_bus_peer #(.OWN_ADDR(PEER)) icc_bus_peer_inst (
		.scl(scl), .sda(sda), .sdaPull(peerPull), .lastByte(peerByte), .nStops(peerStops));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ********
	// tasks
	// ********
	task test_done;
		begin
			$display("compared %0d mismatches %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task guard(input integer k, input integer lim);
		if (k >= lim) begin
			$display("FAIL %0t wait timed out", $time);
			errors = errors + 1;
			test_done;
		end
	endtask
	task chk(input [33:0] got, input [33:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("FAIL %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task axWr(input [7:0] a, input [7:0] v, output [1:0] resp);
		integer k;
		begin
			@(posedge core_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, v};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			k = 0;
			do begin @(posedge core_clk); k = k + 1; end while (s_axi_awready !== 1'b1 && k < 50);
			s_axi_awvalid <= 1'b0;
			s_axi_wvalid <= 1'b0;
			do begin @(posedge core_clk); k = k + 1; end while (s_axi_bvalid !== 1'b1 && k < 100);
			resp = s_axi_bresp;
			s_axi_bready <= 1'b0;
			guard(k, 100);
		end
	endtask
	task axRd(input [7:0] a, output [31:0] v, output [1:0] resp);
		integer k;
		begin
			@(posedge core_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			k = 0;
			do begin @(posedge core_clk); k = k + 1; end while (s_axi_arready !== 1'b1 && k < 50);
			s_axi_arvalid <= 1'b0;
			do begin @(posedge core_clk); k = k + 1; end while (s_axi_rvalid !== 1'b1 && k < 100);
			v = s_axi_rdata;
			resp = s_axi_rresp;
			s_axi_rready <= 1'b0;
			guard(k, 100);
		end
	endtask
	task wrOk(input [7:0] a, input [7:0] v);
		begin
			axWr(a, v, r);
			chk(r, `ICC_RESP_OKAY);
		end
	endtask
	task rdChk(input [7:0] a, input [7:0] m, input [7:0] e);
		begin
			axRd(a, d, r);
			chk({r, d & {24'h000000, m}}, {`ICC_RESP_OKAY, 24'h000000, e});
		end
	endtask
	// polling, not irq: the flag must show with irq enable cleared
	task waitEvt;
		integer n;
		begin
			n = 0;
			do begin axRd(`ICC_OFS_MODE, d, r); n = n + 1; end while (d[7] !== 1'b1 && n < 400);
			guard(n, 400);
		end
	endtask
	// ********
	// tests
	// ********
	initial begin
		rst = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		errors = 0;
		n_compared = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (i = 0; i < 7; i = i + 1)
			rdChk(i[5:0] * 8'h04, 8'hff, RV[55 - 8 * i -: 8]);
		axRd(8'h1c, d, r);
		chk({r, d}, {`ICC_RESP_SLVERR, 32'h00000000});
		axWr(8'h1c, 8'h55, r);
		chk(r, `ICC_RESP_SLVERR);
		$display("test registers done");
		wrOk(`ICC_OFS_LOW, 8'h04);
		wrOk(`ICC_OFS_HIGH, 8'h04);
		wrOk(`ICC_OFS_HOLD, 8'h02);
		rdChk(`ICC_OFS_LOW, 8'hff, 8'h04);
		wrOk(`ICC_OFS_DATA, {PEER + 7'h01, 1'b0});
		wrOk(`ICC_OFS_MODE, 8'h49);
		waitEvt;
		rdChk(`ICC_OFS_STATUS, 8'h89, 8'h00);
		wrOk(`ICC_OFS_DATA, {PEER, 1'b0});
		wrOk(`ICC_OFS_MODE, 8'h49);
		wrOk(`ICC_OFS_STATUS, 8'h00);
		waitEvt;
		rdChk(`ICC_OFS_STATUS, 8'h89, 8'h81);
		chk(peerByte, {PEER, 1'b0});
		$display("test address and restart done");
		wrOk(`ICC_OFS_DATA, 8'ha5);
		wrOk(`ICC_OFS_STATUS, 8'h00);
		waitEvt;
		rdChk(`ICC_OFS_STATUS, 8'h41, 8'h41);
		chk(peerByte, 8'ha5);
		wrOk(`ICC_OFS_MODE, 8'h4a);
		wrOk(`ICC_OFS_STATUS, 8'h00);
		waitEvt;
		rdChk(`ICC_OFS_STATUS, 8'h20, 8'h20);
		chk(peerStops, 8'h01);
		wrOk(`ICC_OFS_STATUS, 8'h00);
		rdChk(`ICC_OFS_MODE, 8'h80, 8'h00);
		$display("test transfer and stop done");
		test_done;
	end
endmodule
